// ---- hdl/event_flags_pkg.sv ----
package event_flags_pkg;
    localparam int CLOCK_HZ = 50_000_000;
    localparam int CYCLES_PER_US = CLOCK_HZ / 1_000_000;
    localparam int FRAME_TIME_US = 1000;
    localparam int CLK_READY_TYPICAL_US = 160;
    localparam int CLK_READY_MAX_US = 1000;
    localparam int FRAME_CYCLES = CYCLES_PER_US * FRAME_TIME_US;
    localparam int CLK_READY_CYCLES = CYCLES_PER_US * CLK_READY_TYPICAL_US;
    localparam int CLK_READY_MAX_CYCLES = CYCLES_PER_US * CLK_READY_MAX_US;
    localparam int CNT_W = 16;
    localparam int REG_W = 16;
    localparam int EVENT_W = 7;
    localparam logic [7:0] CMD_READ_FLAGS = 8'h24;
    localparam logic [7:0] CMD_WRITE_FLAGS = 8'ha4;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] FLAGS_IMPL = 16'h0077;
    localparam int BIT_FRAME_ISO = 0;
    localparam int BIT_ASYNC = 1;
    localparam int BIT_DONE = 2;
    localparam int BIT_OPR = 4;
    localparam int BIT_SUSP = 5;
    localparam int BIT_CLKRDY = 6;
    localparam logic [1:0] RST_SYNC_RESET = 2'h0;
endpackage

// ---- hdl/frame_ticker.sv ----
`timescale 1ns/1ns
module frame_ticker
    import event_flags_pkg::*;
#(
    parameter int PERIOD = FRAME_CYCLES
)
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic run_in,
    output logic tick_out,
    output logic [CNT_W-1:0] count_out
);
    typedef struct packed
    {
        logic [CNT_W-1:0] count;
        logic tick;
    } ticker_state_t;

    ticker_state_t st;
    ticker_state_t next_st;

    // free-running millisecond frame position, halted while idle
    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (run_in)
        begin
            if (st.count == CNT_W'(PERIOD - 1))
            begin
                next_st.count = '0;
                next_st.tick = 1'b1;
            end
            else
            begin
                next_st.count = st.count + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign tick_out = st.tick;
    assign count_out = st.count;
endmodule

// ---- hdl/host_cpu_event_flags.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - wake-up starts a clock-ready wait; bit 6 sets when it ends
// - bit 5 sets when the controller enters suspend
// - suspend request plus all downstream suspended stops frame marks
// - bit 4 sets on an operational-side event
// - bit 2 sets on internal or external end of transfer
// - acknowledged-list results ready make bit 1 pending
// - bit 1 rises at the configured activity position in the frame
// - bit 0 sets at every 1 ms frame mark
// - reads never clear; writing ones clears those bits, ff clears all
// - interrupt pin needs flag, its mask bit and the global enable
// - read code 24, write code a4, all bits reset to zero
module host_cpu_event_flags
    import event_flags_pkg::*;
#(
    parameter int FRAME_CYCLES_P = FRAME_CYCLES,
    parameter int CLK_READY_CYCLES_P = CLK_READY_CYCLES
)
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic cmd_valid_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [REG_W-1:0] cmd_data_in,
    input wire logic wakeup_in,
    input wire logic suspend_request_in,
    input wire logic downstream_suspended_in,
    input wire logic opr_event_in,
    input wire logic internal_eot_in,
    input wire logic transfer_end_signal_in,
    input wire logic async_results_in,
    input wire logic [CNT_W-1:0] activity_cycles_in,
    input wire logic [EVENT_W-1:0] event_mask_in,
    input wire logic global_enable_in,
    output logic [REG_W-1:0] read_data_out,
    output logic read_valid_out,
    output logic int_out,
    output logic sof_out,
    output logic suspended_out
);
    typedef struct packed
    {
        logic [REG_W-1:0] flags;
        logic [REG_W-1:0] read_data;
        logic read_valid;
        logic irq;
        logic sof;
        logic suspended;
        logic suspend_pending;
        logic waking;
        logic [CNT_W-1:0] wake_count;
        logic async_pending;
    } flags_state_t;

    flags_state_t st;
    flags_state_t next_st;
    logic [1:0] rst_sync;
    logic rst_n;
    logic frame_tick;
    logic [CNT_W-1:0] frame_count;
    logic read_hit;
    logic write_hit;
    logic [REG_W-1:0] set_bits;
    logic [REG_W-1:0] clear_bits;

    function automatic logic cmd_hit(input logic valid, input logic [7:0] code,
                                     input logic [7:0] want);
        return valid && (code == want);
    endfunction

    // reset release through two flops
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_sync <= RST_SYNC_RESET;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    frame_ticker #(
        .PERIOD(FRAME_CYCLES_P)
    ) u_frame_ticker (
        .clock_in(clock_in),
        .rst_n_in(rst_n),
        .run_in(!st.suspended),
        .tick_out(frame_tick),
        .count_out(frame_count)
    );

    assign read_hit = cmd_hit(cmd_valid_in, cmd_code_in, CMD_READ_FLAGS);
    assign write_hit = cmd_hit(cmd_valid_in, cmd_code_in, CMD_WRITE_FLAGS);

    always_comb
    begin
        next_st = st;
        set_bits = '0;
        clear_bits = '0;
        next_st.read_valid = 1'b0;
        next_st.sof = 1'b0;
        if (read_hit)
        begin
            next_st.read_data = st.flags;
            next_st.read_valid = 1'b1;
        end
        if (write_hit)
        begin
            clear_bits = cmd_data_in;
        end
        // clock-ready wait after wake-up
        if (st.waking)
        begin
            if (st.wake_count <= 16'h0001)
            begin
                next_st.waking = 1'b0;
                next_st.suspended = 1'b0;
                set_bits[BIT_CLKRDY] = 1'b1;
            end
            else
            begin
                next_st.wake_count = st.wake_count - 16'h0001;
            end
        end
        else if (wakeup_in)
        begin
            next_st.waking = 1'b1;
            next_st.wake_count = CNT_W'(CLK_READY_CYCLES_P);
        end
        // suspend entry
        if (suspend_request_in)
        begin
            next_st.suspend_pending = 1'b1;
        end
        if (st.suspend_pending && downstream_suspended_in && !st.suspended)
        begin
            next_st.suspended = 1'b1;
            next_st.suspend_pending = 1'b0;
            set_bits[BIT_SUSP] = 1'b1;
        end
        set_bits[BIT_OPR] = opr_event_in;
        set_bits[BIT_DONE] = internal_eot_in ||
                             transfer_end_signal_in;
        // acknowledged-list results wait for the activity position
        if (st.async_pending && (frame_count == activity_cycles_in))
        begin
            set_bits[BIT_ASYNC] = 1'b1;
            next_st.async_pending = 1'b0;
        end
        if (async_results_in)
        begin
            next_st.async_pending = 1'b1;
        end
        if (frame_tick && !st.suspended)
        begin
            next_st.sof = 1'b1;
            set_bits[BIT_FRAME_ISO] = 1'b1;
        end
        // set wins over clear
        next_st.flags = ((st.flags & ~clear_bits) | set_bits) &
                        FLAGS_IMPL;
        next_st.irq = global_enable_in &&
                      (|(st.flags[EVENT_W-1:0] & event_mask_in));
    end

    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.flags <= FLAGS_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign read_data_out = st.read_data;
    assign read_valid_out = st.read_valid;
    assign int_out = st.irq;
    assign sof_out = st.sof;
    assign suspended_out = st.suspended;

    // checks
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n);

    property p_clk_ready;
        st.waking && (st.wake_count == 16'h0001) |=>
            st.flags[BIT_CLKRDY] && !st.suspended && !st.waking;
    endproperty
    a_clk_ready: assert property (p_clk_ready)
        else $error("clock ready flag not set after wait");

    property p_wait_bound;
        st.waking |-> (st.wake_count <= CNT_W'(CLK_READY_MAX_CYCLES));
    endproperty
    a_wait_bound: assert property (p_wait_bound)
        else $error("clock ready wait longer than 1 ms");

    property p_suspend;
        st.suspend_pending && downstream_suspended_in && !st.suspended |=>
            st.suspended && st.flags[BIT_SUSP];
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("suspend entry without suspended flag");

    property p_no_sof_suspended;
        st.suspended && $past(st.suspended) |-> !st.sof;
    endproperty
    a_no_sof_suspended: assert property (p_no_sof_suspended)
        else $error("frame mark emitted while suspended");

    property p_opr;
        opr_event_in |=> st.flags[BIT_OPR];
    endproperty
    a_opr: assert property (p_opr)
        else $error("operational event flag missed");

    property p_done;
        write_hit && cmd_data_in[BIT_DONE] &&
            (internal_eot_in || transfer_end_signal_in) |=> st.flags[BIT_DONE];
    endproperty
    a_done: assert property (p_done)
        else $error("transfer done lost against clear");

    property p_async;
        st.async_pending && (frame_count == activity_cycles_in) |=>
            st.flags[BIT_ASYNC];
    endproperty
    a_async: assert property (p_async)
        else $error("acknowledged list flag missed");

    property p_async_time;
        $rose(st.flags[BIT_ASYNC]) |->
            $past(frame_count) == $past(activity_cycles_in);
    endproperty
    a_async_time: assert property (p_async_time)
        else $error("acknowledged list flag at wrong frame position");

    property p_sof;
        frame_tick && !st.suspended |=> st.sof && st.flags[BIT_FRAME_ISO];
    endproperty
    a_sof: assert property (p_sof)
        else $error("frame mark flag missed");

    property p_read_keeps;
        !write_hit |=> ((st.flags & $past(st.flags)) == $past(st.flags));
    endproperty
    a_read_keeps: assert property (p_read_keeps)
        else $error("flag cleared without write");

    property p_irq;
        ##1 st.irq == $past(global_enable_in &&
                            (|(st.flags[EVENT_W-1:0] & event_mask_in)));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt pin disagrees with flags and mask");

    property p_read_data;
        read_hit |=> st.read_valid && (st.read_data == $past(st.flags));
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("flag read returned wrong data");

    c_sof: cover property (st.sof);
    c_suspend_wake: cover property (st.suspended ##1 st.waking);
    c_clear_all: cover property (write_hit && (cmd_data_in == 16'h00ff));
    c_irq: cover property (st.irq);
endmodule

// ---- verif/cpu_host_model.sv ----
`timescale 1ns/1ns
module cpu_host_model
    import event_flags_pkg::*;
(
    input wire logic clock_in,
    input wire logic [REG_W-1:0] read_data_in,
    input wire logic read_valid_in,
    output logic cmd_valid_out,
    output logic [7:0] cmd_code_out,
    output logic [REG_W-1:0] cmd_data_out
);
    initial
    begin
        cmd_valid_out = 1'b0;
        cmd_code_out = 8'h00;
        cmd_data_out = 16'h0000;
    end
    // one command, held up to its taking edge
    task automatic issue(input logic [7:0] code, input logic [15:0] d);
        @(posedge clock_in);
        cmd_valid_out <= 1'b1;
        cmd_code_out <= code;
        cmd_data_out <= d;
        @(posedge clock_in);
        cmd_valid_out <= 1'b0;
        cmd_code_out <= ~code;
        cmd_data_out <= ~d;
    endtask
    // status read comes before any follow-up access
    task automatic read_flags(output logic [15:0] v, output logic ok);
        issue(CMD_READ_FLAGS, 16'h0000);
        @(negedge clock_in);
        ok = (read_valid_in === 1'b1);
        v = read_data_in;
    endtask
    // ones clear the flags seen
    task automatic clear(input logic [15:0] m);
        issue(CMD_WRITE_FLAGS, m);
    endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ns
module tb
    import event_flags_pkg::*;
;
    localparam int FR = 40;
    localparam int CR = 10;
    logic clock_in, arst_n_in, dn_susp, g_en, ok;
    logic [6:0] ev, mask;
    logic [15:0] act, v, cmd_data, read_data;
    logic [7:0] cmd_code;
    logic cmd_valid, read_valid, int_o, sof, susp;
    int err_count, n_tests, n;
    cpu_host_model i_cpu (.clock_in(clock_in), .read_data_in(read_data),
        .read_valid_in(read_valid), .cmd_valid_out(cmd_valid),
        .cmd_code_out(cmd_code), .cmd_data_out(cmd_data));
    host_cpu_event_flags #(.FRAME_CYCLES_P(FR), .CLK_READY_CYCLES_P(CR))
    i_dut (.clock_in(clock_in), .arst_n_in(arst_n_in),
        .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code),
        .cmd_data_in(cmd_data), .wakeup_in(ev[0]),
        .suspend_request_in(ev[1]), .downstream_suspended_in(dn_susp),
        .opr_event_in(ev[2]), .internal_eot_in(ev[3]),
        .transfer_end_signal_in(ev[4]), .async_results_in(ev[5]),
        .activity_cycles_in(act), .event_mask_in(mask),
        .global_enable_in(g_en), .read_data_out(read_data),
        .read_valid_out(read_valid), .int_out(int_o), .sof_out(sof),
        .suspended_out(susp));
    initial
    begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic pulse(input int b);
        @(posedge clock_in);
        ev <= 7'h01 << b;
        @(posedge clock_in);
        ev <= 7'h00;
    endtask
    task automatic rd(input logic [15:0] m, input logic [15:0] exp);
        i_cpu.read_flags(v, ok);
        check({15'h0000, ok}, 16'h0001);
        check(v & m, exp);
    endtask
    task automatic wait_sof;
        for (n = 0; n < 100 && sof !== 1'b1; n++)
            @(negedge clock_in);
        check({15'h0000, sof}, 16'h0001);
    endtask
    task automatic t_events;
        rd(16'hffff, FLAGS_RESET);
        pulse(2);
        pulse(3);
        rd(16'h0014, 16'h0014);
        rd(16'h0014, 16'h0014);
        i_cpu.clear(16'h0004);
        rd(16'h0014, 16'h0010);
        pulse(4);
        rd(16'h0004, 16'h0004);
        i_cpu.clear(16'h0010);
        fork
            i_cpu.clear(16'h0010);
            pulse(2);
        join
        rd(16'h0010, 16'h0010);
        i_cpu.clear(16'h00ff);
        rd(16'hff7f, 16'h0000);
    endtask
    task automatic t_frame;
        wait_sof;
        @(negedge clock_in);
        wait_sof;
        check(16'(n + 1), 16'(FR));
        rd(16'h0001, 16'h0001);
        i_cpu.clear(16'h00ff);
        wait_sof;
        pulse(5);
        rd(16'h0002, 16'h0000);
        repeat (30) @(posedge clock_in);
        rd(16'h0002, 16'h0002);
        i_cpu.clear(16'h00ff);
        act <= 16'h0023;
        wait_sof;
        pulse(5);
        repeat (25) @(posedge clock_in);
        rd(16'h0002, 16'h0000);
        repeat (10) @(posedge clock_in);
        rd(16'h0002, 16'h0002);
    endtask
    task automatic t_int;
        i_cpu.clear(16'h00ff);
        mask <= 7'h04;
        pulse(3);
        repeat (3) @(negedge clock_in);
        check({15'h0000, int_o}, 16'h0000);
        @(posedge clock_in);
        g_en <= 1'b1;
        repeat (3) @(negedge clock_in);
        check({15'h0000, int_o}, 16'h0001);
        @(posedge clock_in);
        mask <= 7'h7a;
        repeat (3) @(negedge clock_in);
        check({15'h0000, int_o}, 16'h0000);
    endtask
    task automatic t_suspend;
        @(posedge clock_in);
        dn_susp <= 1'b1;
        pulse(1);
        repeat (4) @(negedge clock_in);
        check({15'h0000, susp}, 16'h0001);
        rd(16'h0020, 16'h0020);
        for (n = 0; n < 2 * FR; n++)
        begin
            @(negedge clock_in);
            check({15'h0000, sof}, 16'h0000);
        end
        pulse(0);
        rd(16'h0040, 16'h0000);
        repeat (CR + 2) @(negedge clock_in);
        rd(16'h0040, 16'h0040);
        check({15'h0000, susp}, 16'h0000);
    endtask
    initial
    begin
        err_count = 0;
        n_tests = 0;
        arst_n_in = 1'b0;
        ev = 7'h00;
        mask = 7'h00;
        g_en = 1'b0;
        dn_susp = 1'b0;
        act = 16'h0014;
        repeat (5) @(posedge clock_in);
        arst_n_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        t_events;
        t_frame;
        t_int;
        t_suspend;
        complete_run;
    end
    initial
    begin
        #(20 * 5000);
        err_count++;
        complete_run;
    end
endmodule
